// *** src/genlock_video_digitizer_core.sv ***
// Digital genlock core: filter, sync separator, clamp, serial control
`timescale 1ns/1ps
`include "genlock_defs.svh"

module genlock_video_digitizer_core
  import genlock_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        synth_clk_i,
  input  wire logic        pixel_clock_2x_i,
  input  wire logic [7:0]  adc_data_i,
  input  wire logic [15:0] burst_phase_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  output      logic [31:0] wb_dat_o,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output      logic        wb_ack_o,
  output      logic        pixel_qual_o,
  output      logic        horiz_sync_out_o,
  output      logic        vert_sync_out_o,
  output      logic [7:0]  video_out_bus_o,
  output      logic        synth_reference_out_o,
  output      logic [1:0]  input_sel_o,
  output      logic        rate_135_o,
  output      logic [7:0]  gain_o,
  output      logic        locked_o
);

  // Pin synchronisers, two flops each
  logic [1:0] pxs_r;           // 2x clock sampler
  logic [1:0] sys_r;           // 20 MHz sampler
  logic       px_d_r;          // Previous synced 2x level
  logic       sy_d_r;          // Previous synced 20 MHz level
  logic [7:0] adc_s1_r;        // ADC sync stage one
  logic [7:0] adc_r;           // ADC sync stage two
  logic       px_rise;         // 2x clock rising edge
  logic       sy_rise;         // 20 MHz rising edge

  // Sample the pin clocks and data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pxs_r    <= 2'b00;
      sys_r    <= 2'b00;
      px_d_r   <= 1'b0;
      sy_d_r   <= 1'b0;
      adc_s1_r <= 8'h00;
      adc_r    <= 8'h00;
    end else begin
      pxs_r    <= {pxs_r[0], pixel_clock_2x_i};
      sys_r    <= {sys_r[0], synth_clk_i};
      px_d_r   <= pxs_r[1];
      sy_d_r   <= sys_r[1];
      adc_s1_r <= adc_data_i;
      adc_r    <= adc_s1_r;
    end
  end

  assign px_rise = pxs_r[1] & ~px_d_r;
  assign sy_rise = sys_r[1] & ~sy_d_r;

  // Wishbone and control shift register
  logic [`CTRL_BITS-1:0] shift_r;   // Serial shift register
  logic [5:0]            cnt_r;     // Bits moved this transfer
  ctrl_type              ctrl_r;    // Applied control
  logic                  ack_r;     // Bus acknowledge
  logic [31:0]           rdat_r;    // Read data
  logic                  req;       // New bus request
  logic                  shift_hit; // Access at shift address
  lock_state_type        st_r;      // Acquisition state

  assign req       = wb_cyc_i & wb_stb_i & ~ack_r;
  assign shift_hit = req & (wb_adr_i == `WB_ADDR_SHIFT);

  // One-cycle ack, any address answers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r  <= 1'b0;
      rdat_r <= 32'h0000_0000;
    end else begin
      ack_r <= req;
      if (req && !wb_we_i) begin
        case (wb_adr_i)
          `WB_ADDR_SHIFT:  rdat_r <= {31'h0000_0000, shift_r[0]};
          `WB_ADDR_STATUS: rdat_r <= {24'h00_0000, cnt_r, 2'(st_r)};
          default:         rdat_r <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Shift one bit per access, apply after 47
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      shift_r <= '0;
      cnt_r   <= 6'd0;
      ctrl_r  <= '0;
    end else if (shift_hit) begin
      // Write takes LSB; read rotates bit out
      shift_r <= {(wb_we_i & wb_sel_i[0]) ? wb_dat_i[0] : shift_r[0],
                  shift_r[`CTRL_BITS-1:1]};
      if (cnt_r == 6'(`CTRL_BITS - 1)) begin
        cnt_r <= 6'd0;
        if (wb_we_i)
          ctrl_r <= ctrl_type'({wb_dat_i[0],
                                shift_r[`CTRL_BITS-1:`CTRL_BITS-8]});
      end else begin
        cnt_r <= cnt_r + 6'd1;
      end
    end
  end

  assign wb_ack_o    = ack_r;
  assign wb_dat_o    = rdat_r;
  assign input_sel_o = ctrl_r.input_sel;
  assign rate_135_o  = ctrl_r.rate_135;

  // Low-pass filter: four tap moving average
  logic [7:0] tap_r [0:3];     // Sample history
  logic [9:0] sum;             // Tap sum
  logic [7:0] lpf_r;           // Filtered sample
  assign sum = 10'(tap_r[0]) + 10'(tap_r[1])
             + 10'(tap_r[2]) + 10'(tap_r[3]);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < 4; i++)
        tap_r[i] <= 8'h00;
      lpf_r <= 8'h00;
    end else if (px_rise) begin
      tap_r[0] <= adc_r;
      for (int i = 1; i < 4; i++)
        tap_r[i] <= tap_r[i-1];
      lpf_r <= sum[9:2];
    end
  end

  // Sync separator on filtered data
  logic        tip;            // Below sync threshold
  logic        tip_d_r;        // Previous tip state
  logic [9:0]  tip_len_r;      // Tip length in 2x clocks
  logic        hsync_r;        // Horizontal sync output
  logic        vsync_r;        // Vertical sync output
  logic        line_end;       // Tip just ended
  logic [7:0]  porch_r;        // Measured back porch
  logic [7:0]  tip_lvl_r;      // Measured sync tip
  logic [5:0]  porch_cnt_r;    // Clocks since tip end
  assign tip      = lpf_r < `SYNC_THRESH;
  assign line_end = px_rise & tip_d_r & ~tip;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tip_d_r   <= 1'b0;
      tip_len_r <= 10'd0;
      hsync_r   <= 1'b0;
      vsync_r   <= 1'b0;
    end else if (px_rise) begin
      tip_d_r <= tip;
      if (tip) begin
        if (tip_len_r != 10'h3ff)
          tip_len_r <= tip_len_r + 10'd1;
        hsync_r <= (tip_len_r >= 10'(`SYNC_TIP_MIN));
        if (tip_len_r >= `VSYNC_MIN)
          vsync_r <= 1'b1;
      end else begin
        tip_len_r <= 10'd0;
        hsync_r   <= 1'b0;
        if (tip_d_r && tip_len_r < `VSYNC_MIN)
          vsync_r <= 1'b0;
      end
    end
  end

  // Porch and tip level detectors
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      porch_r     <= `BLANK_NTSC;
      tip_lvl_r   <= 8'h00;
      porch_cnt_r <= 6'd63;
    end else if (px_rise) begin
      if (line_end)
        porch_cnt_r <= 6'd0;
      else if (porch_cnt_r != 6'd63)
        porch_cnt_r <= porch_cnt_r + 6'd1;
      if (porch_cnt_r == 6'd40)
        porch_r <= lpf_r;
      if (tip && tip_len_r == 10'd8)
        tip_lvl_r <= lpf_r;
    end
  end

  // Lock state: loss counts 2x clocks / 256 without sync
  logic [7:0] nosync_r;        // 2x clocks / 256 since sync
  logic [7:0] nosync_lo_r;     // Low count
  logic [9:0] lines_r;         // Lines seen in acquisition
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r        <= ACQUIRE;
      nosync_r    <= 8'd0;
      nosync_lo_r <= 8'd0;
      lines_r     <= 10'd0;
    end else if (px_rise) begin
      if (line_end) begin
        nosync_r    <= 8'd0;
        nosync_lo_r <= 8'd0;
      end else begin
        nosync_lo_r <= nosync_lo_r + 8'd1;
        if (nosync_lo_r == 8'hff && nosync_r != 8'hff)
          nosync_r <= nosync_r + 8'd1;
      end
      case (st_r)
        ACQUIRE: begin
          if (line_end)
            lines_r <= lines_r + 10'd1;
          if (lines_r == 10'd8)
            st_r <= LOCKED;
        end
        LOCKED: begin
          if (nosync_r >= `LOSS_LINES)
            st_r <= LOST;
        end
        LOST: begin
          lines_r <= 10'd0;
          if (line_end)
            st_r <= ACQUIRE;
        end
        default: st_r <= ACQUIRE;
      endcase
    end
  end
  assign locked_o = (st_r == LOCKED);

  // Gain: from tip to porch amplitude
  logic [7:0] gain_r;          // Gain, 8'h40 is unity
  logic [7:0] nominal;         // Selected nominal gain
  assign nominal = ctrl_r.gain_hi ? 8'h60 : 8'h40;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gain_r <= 8'h40;
    end else if (!ctrl_r.agc_en) begin
      gain_r <= nominal;
    end else if (line_end && (st_r == ACQUIRE || !ctrl_r.agc_hold)) begin
      // raise when amplitude short of 40 codes
      if ((porch_r - tip_lvl_r) < 8'd40 && gain_r != 8'hff)
        gain_r <= gain_r + 8'd1;
      else if ((porch_r - tip_lvl_r) > 8'd40 && gain_r > nominal)
        gain_r <= gain_r - 8'd1;
    end
  end
  assign gain_o = gain_r;

  // Synth reference: divide 2x clock by nine, on 20 MHz
  logic [3:0] div_r;           // Divider count
  logic       ref_r;           // Reference level
  logic       pend_r;          // 2x edge awaiting synth tick
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_r  <= 4'd0;
      ref_r  <= 1'b0;
      pend_r <= 1'b0;
    end else begin
      if (px_rise)
        pend_r <= 1'b1;
      else if (sy_rise)
        pend_r <= 1'b0;
      if (sy_rise && pend_r) begin
        if (div_r == `DDS_DIV - 4'd1) begin
          div_r <= 4'd0;
          ref_r <= 1'b1;
        end else begin
          div_r <= div_r + 4'd1;
          if (div_r == 4'd3)
            ref_r <= 1'b0;
        end
      end
    end
  end
  assign synth_reference_out_o = ref_r;

  // Output: clamp, nibble insertion, qualifier
  video_out_type vo_r;         // Registered output bundle
  logic [7:0]    blank;        // Target blank level
  logic [15:0]   freq;         // Reference frequency word
  logic [1:0]    nib_r;        // Nibble index
  logic          field_r;      // Field identity
  assign blank = ctrl_r.format[0] ? `BLANK_PAL : `BLANK_NTSC;
  assign freq  = (st_r == LOCKED) ? burst_phase_i
               : (ctrl_r.format[0] ? `FREQ_INIT_PAL
                                   : `FREQ_INIT_NTSC);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vo_r    <= '0;
      nib_r   <= 2'd0;
      field_r <= 1'b0;
    end else if (px_rise) begin
      vo_r.qual  <= ~vo_r.qual;
      vo_r.hsync <= hsync_r;
      vo_r.vsync <= vsync_r;
      if (vsync_r && line_end)
        field_r <= ~field_r;
      if (hsync_r) begin
        nib_r <= nib_r + 2'd1;
        case (nib_r)
          2'd0: vo_r.data <= {4'h0, freq[15:12]};
          2'd1: vo_r.data <= {4'h0, freq[11:8]};
          2'd2: vo_r.data <= {4'h0, freq[7:4]};
          default: vo_r.data <= {3'h0, field_r, freq[3:0]} & 8'h0f;
        endcase
      end else begin
        nib_r <= 2'd0;
        if (ctrl_r.clamp_en)
          vo_r.data <= adc_r - porch_r + blank;
        else
          vo_r.data <= adc_r;
      end
    end
  end

  assign pixel_qual_o     = vo_r.qual;
  assign horiz_sync_out_o = vo_r.hsync;
  assign vert_sync_out_o  = vo_r.vsync;
  assign video_out_bus_o  = vo_r.data;

endmodule

// *** common/genlock_defs.svh ***
// Constants for the genlock video digitizer core
`ifndef GENLOCK_DEFS_SVH
`define GENLOCK_DEFS_SVH
`define CTRL_BITS        47
`define WB_ADDR_DATA     4'h0
`define WB_ADDR_SHIFT    4'h4
`define WB_ADDR_STATUS   4'h8
`define FLD_INPUT_SEL    0
`define FLD_FORMAT       2
`define FLD_RATE_135     4
`define FLD_GAIN_HI      5
`define FLD_AGC_EN       6
`define FLD_AGC_HOLD     7
`define FLD_CLAMP_EN     8
`define BLANK_NTSC       8'h3c
`define BLANK_PAL        8'h40
`define SYNC_THRESH      8'h20
`define SYNC_TIP_MIN     8'd24
`define VSYNC_MIN        10'd400
`define DDS_DIV          4'd9
`define FREQ_INIT_NTSC   16'h21f0
`define FREQ_INIT_PAL    16'h2a09
`define LOSS_LINES       8'd16
`define LOCK_LINES       10'd1050
`endif

// *** common/genlock_pkg.sv ***
// Types for the genlock video digitizer core
package genlock_pkg;
  typedef struct packed {
    logic       clamp_en;
    logic       agc_hold;
    logic       agc_en;
    logic       gain_hi;
    logic       rate_135;
    logic [1:0] format;
    logic [1:0] input_sel;
  } ctrl_type;
  typedef struct packed {
    logic       hsync;
    logic       vsync;
    logic       qual;
    logic [7:0] data;
  } video_out_type;
  typedef enum logic [1:0] {ACQUIRE, LOCKED, LOST} lock_state_type;
endpackage

// *** verif/video_source.sv ***
// Video source model: line-locked 2x clock, samples, burst word
`timescale 1ns/1ps
module video_source (
  input  wire logic [7:0]  porch_i,
  input  wire logic [7:0]  active_i,
  output      logic        pixel_clock_2x_o,
  output      logic [7:0]  adc_data_o,
  output      logic [15:0] burst_phase_o
);
  int pos; // Place within the line
  // Free-running 2x clock, 160 ns
  initial begin
    pos = 0;
    adc_data_o = 8'h00;
    burst_phase_o = 16'h0000;
    pixel_clock_2x_o = 1'b0;
    forever #80 pixel_clock_2x_o = ~pixel_clock_2x_o;
  end
  // Line of 32 tip, 48 porch, 32 active clocks
  always @(posedge pixel_clock_2x_o) begin
    pos <= (pos == 111) ? 0 : pos + 1;
    burst_phase_o <= burst_phase_o + 16'h0123;
    if (pos < 32) begin
      adc_data_o <= 8'h08;
    end else if (pos < 80) begin
      adc_data_o <= porch_i;
    end else begin
      adc_data_o <= active_i;
    end
  end
endmodule

// *** verif/genlock_core_checker_sva.sv ***
// Port checker for the genlock digitizer core
`timescale 1ns/1ps
module genlock_core_checker (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_we_i,
  input wire logic       wb_ack_o,
  input wire logic       pixel_qual_o,
  input wire logic [7:0] video_out_bus_o,
  input wire logic       synth_reference_out_o,
  input wire logic [1:0] input_sel_o,
  input wire logic       rate_135_o,
  input wire logic [7:0] gain_o,
  input wire logic       locked_o
);
  // One clock domain throughout
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack_next;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("late ack");
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("long ack");
  property p_ack_cause;
    $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("stray ack");
  property p_qual_rate;
    $changed(pixel_qual_o) |-> ##[36:44] $changed(pixel_qual_o);
  endproperty
  a_qual_rate: assert property (p_qual_rate) else $error("qual rate");
  property p_video_hold;
    $changed(video_out_bus_o) |=> $stable(video_out_bus_o) [*8];
  endproperty
  a_video_hold: assert property (p_video_hold) else $error("data");
  property p_synth_hold;
    $changed(synth_reference_out_o) |=> $stable(synth_reference_out_o) [*8];
  endproperty
  a_synth_hold: assert property (p_synth_hold) else $error("synth");
  property p_reset_state;
    $fell(rst_i) |-> gain_o == 8'h40 && !locked_o && video_out_bus_o == 8'h00;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("reset");
  property p_ctrl_apply;
    $changed({input_sel_o, rate_135_o})
      |-> $past(wb_cyc_i && wb_we_i) || $past(wb_cyc_i && wb_we_i, 2);
  endproperty
  a_ctrl_apply: assert property (p_ctrl_apply) else $error("ctrl");
endmodule
bind genlock_video_digitizer_core genlock_core_checker checker_i (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o), .pixel_qual_o(pixel_qual_o),
  .video_out_bus_o(video_out_bus_o), .input_sel_o(input_sel_o),
  .synth_reference_out_o(synth_reference_out_o), .rate_135_o(rate_135_o),
  .gain_o(gain_o), .locked_o(locked_o));

// *** verif/genlock_video_digitizer_core_tb.sv ***
// Testbench for the genlock digitizer core
`timescale 1ns/1ps
`include "genlock_defs.svh"
module genlock_video_digitizer_core_tb import genlock_pkg::*;;
  logic        clk_i, rst_i, synth_clk, we, cyc, stb, ack, pclk, lock;
  logic [3:0]  adr;
  logic [31:0] dat_w, dat_r, r;
  logic [7:0]  adc, vid, gain, porch, active;
  logic [15:0] burst;
  logic [1:0]  sel;
  logic        rate;
  logic [46:0] sh;          // Bits written in this transfer
  logic [31:0] seed = 32'h6a19_7563;
  logic [31:0] exp_q[$];    // Expected read data
  int          fails = 0;
  int          n_compared = 0;
  ctrl_type    c, cur;
  genlock_video_digitizer_core genlock_video_digitizer_core_i (
    .clk_i(clk_i), .rst_i(rst_i), .synth_clk_i(synth_clk),
    .pixel_clock_2x_i(pclk), .adc_data_i(adc), .burst_phase_i(burst),
    .wb_adr_i(adr), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_we_i(we),
    .wb_sel_i(4'hf), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack),
    .pixel_qual_o(), .horiz_sync_out_o(), .vert_sync_out_o(),
    .video_out_bus_o(vid), .synth_reference_out_o(), .input_sel_o(sel),
    .rate_135_o(rate), .gain_o(gain), .locked_o(lock));
  video_source video_source_i (.porch_i(porch), .active_i(active),
    .pixel_clock_2x_o(pclk), .adc_data_o(adc), .burst_phase_o(burst));
  // Clocks: 4 ns core, 50 ns synthesizer
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  initial begin
    synth_clk = 1'b0;
    forever #25 synth_clk = ~synth_clk;
  end
  // Xorshift source
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  // One classic Wishbone cycle, bounded wait for ack
  task automatic wb(logic [3:0] a, logic w, logic [31:0] d);
    int t;
    t = 0;
    adr <= a;
    we <= w;
    dat_w <= d;
    cyc <= 1'b1;
    stb <= 1'b1;
    do @(posedge clk_i); while (ack !== 1'b1 && ++t < 50);
    if (t >= 50) fails++;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(logic [3:0] a, logic [31:0] e);
    exp_q.push_back(e);
    wb(a, 1'b0, 32'h0000_0000);
  endtask
  // Read data compared as each read ack appears
  always @(posedge clk_i) begin
    if (ack === 1'b1 && we === 1'b0) begin
      chk("rdata", exp_q.pop_front(), dat_r);
    end
  end
  // Shift a whole control word in, random padding first
  task automatic load(ctrl_type v);
    for (int i = 0; i < 47; i++) begin
      r = xs();
      sh[i] = (i < 38) ? r[0] : v[i-38];
      if (i == 46) chk("partial", cur.input_sel, sel);
      wb(`WB_ADDR_SHIFT, 1'b1, {r[31:1], sh[i]});
    end
    cur = v;
  endtask
  task automatic await(string nm, logic [7:0] e, ref logic [7:0] s);
    int t;
    t = 0;
    while (s !== e && t < 9000) begin
      @(posedge clk_i);
      t++;
    end
    chk(nm, e, s);
  endtask
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (95000) @(posedge clk_i);
    fails++;
    end_of_test();
  end
  // Main sequence
  initial begin
    rst_i = 1'b1;
    {we, cyc, stb, adr, dat_w} = '0;
    porch = 8'h50;
    active = 8'h90;
    cur = '0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk("gain_rst", 8'h40, gain);
    for (int k = 0; k < 4; k++) begin
      c = '0;
      c.input_sel = k[1:0];
      c.rate_135 = k[0];
      c.gain_hi = k[1];
      c.format = {1'b0, k[0]};
      c.clamp_en = 1'b1;
      load(c);
      repeat (3) @(posedge clk_i);
      chk("sel", k[1:0], sel);
      chk("rate", k[0], rate);
      await("gain", k[1] ? 8'h60 : 8'h40, gain);
      for (int i = 0; i < 47; i++) rd(`WB_ADDR_SHIFT, sh[i]);
      await("clamp", active - porch + (k[0] ? `BLANK_PAL : `BLANK_NTSC),
            vid);
    end
    wb(4'hc, 1'b1, xs());
    rd(4'hc, 32'h0000_0000);
    for (int t = 0; t < 60000 && lock !== 1'b1; t++) @(posedge clk_i);
    chk("lock", 1'b1, lock);
    end_of_test();
  end
endmodule
